// ---- asol_defs.svh ----
// Offsets, field positions, reset values and supply limits of the alarm/offset block.
// Assumes inclusion by bare name from the core module.
`ifndef ASOL_DEFS_SVH
`define ASOL_DEFS_SVH
// ----------------------------------------------------------------------
// Word indices on the register port (byte address = 2 * index)
// ----------------------------------------------------------------------
`define ASOL_W_OFF0 5'h00
`define ASOL_W_THR0 5'h05
`define ASOL_W_CNT0 5'h07
`define ASOL_W_CFG 5'h09
`define ASOL_W_CMD 5'h0A
`define ASOL_W_STAT 5'h0B
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASOL_CMD_CLR 4
`define ASOL_CMD_FAC 1
`define ASOL_CMD_NULL 0
`define ASOL_THR_POL 15
`define ASOL_CFG_SRC 8
`define ASOL_CFG_ROC 5
`define ASOL_CFG_FILT 3
`define ASOL_CFG_IEN 2
`define ASOL_CFG_IPOL 1
`define ASOL_CFG_ISEL 0
`define ASOL_ST_ALM 8
`define ASOL_ST_TEST 5
`define ASOL_ST_SPI 3
`define ASOL_ST_FLASH 2
`define ASOL_ST_HI 1
`define ASOL_ST_LO 0
// ----------------------------------------------------------------------
// Reset values, masks and supply limits
// ----------------------------------------------------------------------
`define ASOL_CNT_RST 8'h01
`define ASOL_CFG_MASK 16'hFF7F
`define ASOL_THR_MASK 16'hBFFF
`define ASOL_SUP_HI_MV 3625
`define ASOL_SUP_LO_MV 2975
`define ASOL_SUP_UV_LSB 1000
`endif

// ---- asol_pkg.sv ----
// Types shared by the alarm/offset block.
// Assumes asol_defs.svh is on the include path.
package asol_pkg;
  typedef logic [13:0] asol_word_t;
  typedef struct packed {
    logic [4:0][13:0] off;
    logic [1:0][15:0] thr;
    logic [1:0][7:0]  cnt;
    logic [15:0]      cfg;
    logic [9:0]       stat;
    logic [1:0][14:0] prev;
    logic [1:0]       have;
    logic [1:0][23:0] acc;
    logic [1:0][7:0]  seen;
    logic [15:0]      rd;
    logic [4:0][13:0] corr;
    logic             l1o;
    logic             l1e;
    logic             l2o;
    logic             l2e;
  } asol_state_s;
endpackage : asol_pkg

// ---- asol_core.sv ----
// Offset registers, dual alarm comparator, status flags and alarm indicator lines.
// Assumes a word register port, synchronous sample data and one 25 MHz clock.
`timescale 1ns/1ns
`include "asol_defs.svh"

// Summary of operation
// - Acceleration offsets: 14-bit signed, top two bits read zero, reset zero.
// - Incline and rotation offsets: 14-bit signed, top two bits read zero.
// - Two alarm channels evaluate independently with their own settings.
// - Rate mode averages sample differences over the count, compares to threshold.
// - Threshold bit 15 picks greater-than when one, less-than when zero.
// - Threshold field uses the number format of the chosen source.
// - Sample count bits 7:0; codes zero and one mean one; resets to one.
// - Config nibbles select alarm sources; zero disables, codes one to eight.
// - Config bits 6 and 5 enable rate mode, else static comparison.
// - Config bits 4 and 3 pick filtered data; incline and rotation always filtered.
// - Config bit 2 drives the alarm indicator on a general line.
// - Config bit 1 makes the indicator active high, else active low.
// - Config bit 0 selects line two when one, line one when zero.
// - Status bits 9 and 8 show alarm two and alarm one active.
// - Command bit 4 write clears status bits 9 to 2; supply bits 1 and 0 follow the supply.
// - Status bits 5, 3, 2 flag self-test, link and flash failures.
// - Status bit 1 for supply above 3.625 V, bit 0 below 2.975 V.
// - Low-supply flag clears itself once supply rises above the limit.
// - Command bit 1 zeroes offsets; bit 0 loads negated current outputs.
module asol_core (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             regWr,
  input  wire logic [5:0]       regAddr,
  input  wire logic [15:0]      regWdata,
  output logic      [15:0]      regRdata,
  input  wire logic             sampleValid,
  input  wire logic [7:0][13:0] unfData,
  input  wire logic [7:0][13:0] filtData,
  input  wire logic             selfTestFail,
  input  wire logic             spiFail,
  input  wire logic             flashFail,
  output logic      [4:0][13:0] corrOut,
  output logic                  lineOneOut,
  output logic                  lineOneOe,
  output logic                  lineTwoOut,
  output logic                  lineTwoOe
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  localparam logic [13:0] SupHi = 14'(`ASOL_SUP_HI_MV * 1000 / `ASOL_SUP_UV_LSB);
  localparam logic [13:0] SupLo = 14'(`ASOL_SUP_LO_MV * 1000 / `ASOL_SUP_UV_LSB);

  // Data input slot of the output that offset register i corrects.
  function automatic logic [2:0] offSlot(input int i);
    case (i)
      0:       offSlot = 3'h1;
      1:       offSlot = 3'h2;
      2:       offSlot = 3'h5;
      3:       offSlot = 3'h6;
      default: offSlot = 3'h7;
    endcase
  endfunction : offSlot

  // Offset register for a source code; 7 means the source has none.
  function automatic logic [2:0] offOfSrc(input logic [3:0] src);
    case (src)
      4'h2:    offOfSrc = 3'h0;
      4'h3:    offOfSrc = 3'h1;
      4'h6:    offOfSrc = 3'h2;
      4'h7:    offOfSrc = 3'h3;
      4'h8:    offOfSrc = 3'h4;
      default: offOfSrc = 3'h7;
    endcase
  endfunction : offOfSrc

  // Supply, auxiliary converter and temperature are unsigned codes.
  function automatic logic [14:0] extend(input logic [3:0] src, input logic [13:0] v);
    if (src == 4'h1 || src == 4'h4 || src == 4'h5) begin
      extend = {1'b0, v};
    end else begin
      extend = {v[13], v};
    end
  endfunction : extend

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  asol_pkg::asol_state_s q;
  asol_pkg::asol_state_s d;
  logic                  cmdWr;
  logic [1:0]            chValid;
  logic [1:0]            chHit;
  logic [1:0][14:0]      curV;
  logic [1:0][14:0]      thrV;

  always_comb begin
    logic [3:0]        src;
    logic [2:0]        oi;
    logic [13:0]       raw;
    logic [7:0]        nEff;
    logic signed [23:0] accN;
    logic signed [23:0] lim;
    logic signed [15:0] diff;
    src = 4'h0;
    oi = 3'h0;
    raw = 14'h0000;
    nEff = 8'h01;
    accN = 24'sh000000;
    lim = 24'sh000000;
    diff = 16'sh0000;
    d = q;
    d.rd = 16'h0000;
    chValid = 2'b00;
    chHit = 2'b00;
    curV = '0;
    thrV = '0;
    cmdWr = regWr && regAddr[5:1] == `ASOL_W_CMD;
    for (int i = 0; i < 5; i++) begin
      if (regWr && regAddr[5:1] == 5'(`ASOL_W_OFF0 + i)) begin
        d.off[i] = regWdata[13:0];
      end
      if (regAddr[5:1] == 5'(`ASOL_W_OFF0 + i)) begin
        d.rd = {2'b00, q.off[i]};
      end
      d.corr[i] = filtData[offSlot(i)] + q.off[i];
    end
    if (cmdWr && regWdata[`ASOL_CMD_NULL]) begin
      for (int i = 0; i < 5; i++) begin
        d.off[i] = 14'(-filtData[offSlot(i)]);
      end
    end
    if (cmdWr && regWdata[`ASOL_CMD_FAC]) begin
      d.off = '0;
    end
    if (regWr && regAddr[5:1] == `ASOL_W_CFG) begin
      d.cfg = regWdata & `ASOL_CFG_MASK;
    end
    if (regAddr[5:1] == `ASOL_W_CFG) begin
      d.rd = q.cfg;
    end
    if (regAddr[5:1] == `ASOL_W_STAT) begin
      d.rd = {6'h00, q.stat};
    end
    if (cmdWr && regWdata[`ASOL_CMD_CLR]) begin
      d.stat = '0;
    end
    // Each channel runs the same logic on its own fields.
    for (int ch = 0; ch < 2; ch++) begin
      if (regWr && regAddr[5:1] == 5'(`ASOL_W_THR0 + ch)) begin
        d.thr[ch] = regWdata & `ASOL_THR_MASK;
      end
      if (regWr && regAddr[5:1] == 5'(`ASOL_W_CNT0 + ch)) begin
        d.cnt[ch] = regWdata[7:0];
      end
      if (regAddr[5:1] == 5'(`ASOL_W_THR0 + ch)) begin
        d.rd = q.thr[ch];
      end
      if (regAddr[5:1] == 5'(`ASOL_W_CNT0 + ch)) begin
        d.rd = {8'h00, q.cnt[ch]};
      end
      src = q.cfg[`ASOL_CFG_SRC + 4 * ch +: 4];
      chValid[ch] = src >= 4'h1 && src <= 4'h8;
      oi = offOfSrc(src);
      if (q.cfg[`ASOL_CFG_FILT + ch] || src >= 4'h6) begin
        raw = filtData[3'(src - 4'h1)];
      end else begin
        raw = unfData[3'(src - 4'h1)];
      end
      if (oi != 3'h7) begin
        raw = raw + q.off[oi];
      end
      curV[ch] = extend(src, raw);
      thrV[ch] = extend(src, q.thr[ch][13:0]);
      nEff = (q.cnt[ch] < 8'h02) ? 8'h01 : q.cnt[ch];
      if (sampleValid && chValid[ch]) begin
        if (!q.cfg[`ASOL_CFG_ROC + ch]) begin
          if (q.thr[ch][`ASOL_THR_POL]) begin
            chHit[ch] = $signed(curV[ch]) > $signed(thrV[ch]);
          end else begin
            chHit[ch] = $signed(curV[ch]) < $signed(thrV[ch]);
          end
        end else if (q.have[ch]) begin
          diff = $signed({curV[ch][14], curV[ch]}) - $signed({q.prev[ch][14], q.prev[ch]});
          accN = $signed(q.acc[ch]) + 24'(diff);
          d.acc[ch] = accN;
          d.seen[ch] = q.seen[ch] + 8'h01;
          if (q.seen[ch] + 8'h01 >= nEff) begin
            // Comparing sum with threshold times count avoids a divider.
            lim = 24'(signed'(thrV[ch])) * 24'(signed'({1'b0, nEff}));
            if (q.thr[ch][`ASOL_THR_POL]) begin
              chHit[ch] = accN > lim;
            end else begin
              chHit[ch] = accN < lim;
            end
            d.acc[ch] = '0;
            d.seen[ch] = 8'h00;
          end
        end
        d.prev[ch] = curV[ch];
        d.have[ch] = 1'b1;
      end
      if (chHit[ch]) begin
        d.stat[`ASOL_ST_ALM + ch] = 1'b1;
      end
    end
    if (selfTestFail) begin
      d.stat[`ASOL_ST_TEST] = 1'b1;
    end
    if (spiFail) begin
      d.stat[`ASOL_ST_SPI] = 1'b1;
    end
    if (flashFail) begin
      d.stat[`ASOL_ST_FLASH] = 1'b1;
    end
    d.stat[`ASOL_ST_HI] = filtData[0] > SupHi;
    d.stat[`ASOL_ST_LO] = filtData[0] < SupLo;
    // Indicator follows the sticky alarm bits; undriven when disabled.
    d.l1e = q.cfg[`ASOL_CFG_IEN] && !q.cfg[`ASOL_CFG_ISEL];
    d.l2e = q.cfg[`ASOL_CFG_IEN] && q.cfg[`ASOL_CFG_ISEL];
    d.l1o = (|q.stat[9:8]) ~^ q.cfg[`ASOL_CFG_IPOL];
    d.l2o = d.l1o;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.cnt <= {`ASOL_CNT_RST, `ASOL_CNT_RST};
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rd;
  assign corrOut = q.corr;
  assign lineOneOut = q.l1o;
  assign lineOneOe = q.l1e;
  assign lineTwoOut = q.l2o;
  assign lineTwoOe = q.l2e;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reset_values: assert property ($past(rst) |-> q.off == '0 && q.cnt[0] == 8'h01
    && q.cnt[1] == 8'h01 && q.stat == '0) else $error("reset values wrong");
  chk_offset_readback: assert property (regWr && regAddr[5:1] == `ASOL_W_OFF0
    && !$past(rst) ##1 regAddr[5:1] == `ASOL_W_OFF0 |=> regRdata[15:14] == 2'b00
    && regRdata[13:0] == $past(regWdata[13:0], 2)) else $error("offset readback wrong");
  chk_status_clear: assert property (cmdWr && regWdata[`ASOL_CMD_CLR] && !chHit[0]
    && !chHit[1] && !selfTestFail && !spiFail && !flashFail |=> q.stat[9:2] == '0)
    else $error("status not cleared");
  chk_alarm_disabled: assert property (!chValid[0] && !q.stat[8] |=> !q.stat[8])
    else $error("disabled alarm went active");
  chk_static_compare: assert property (sampleValid && chValid[0] && !q.cfg[5]
    && q.thr[0][15] && $signed(curV[0]) > $signed(thrV[0]) |=> q.stat[8])
    else $error("static alarm missed");
  chk_alarm_sticky: assert property (q.stat[9] && !(cmdWr && regWdata[`ASOL_CMD_CLR])
    |=> q.stat[9]) else $error("alarm bit dropped");
  chk_low_supply: assert property (filtData[0] >= SupLo |=> !q.stat[0])
    else $error("low supply flag stuck");
  chk_high_supply: assert property (filtData[0] > SupHi |=> q.stat[1])
    else $error("high supply flag missing");
  chk_indicator_level: assert property (q.cfg[2] && !q.cfg[0] && $stable(q.cfg)
    |=> lineOneOe && !lineTwoOe && lineOneOut == ($past(q.cfg[1]) ~^ $past(|q.stat[9:8])))
    else $error("indicator line wrong");
  chk_autonull_load: assert property (cmdWr && regWdata[0] && !regWdata[1]
    |=> q.off[0] == 14'(-$past(filtData[1]))) else $error("autonull wrong");
  chk_factory_restore: assert property (cmdWr && regWdata[1] |=> q.off == '0)
    else $error("restore wrong");

endmodule : asol_core

// ---- asol_host.sv ----
// Host model that reaches the block registers one word at a time.
// Assumes a one-cycle write strobe and a one-cycle registered read.
`timescale 1ns/1ns
module asol_host (
  input  wire logic        clk,
  output logic             regWr,
  output logic [5:0]       regAddr,
  output logic [15:0]      regWdata,
  input  wire logic [15:0] regRdata
);
  initial begin
    regWr = 1'h0;
    regAddr = 6'h3F;
    regWdata = 16'h0000;
  end

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
    regWdata <= ~d;
  endtask : wr

  // The address is held until the registered answer has been taken.
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    @(posedge clk);
    d = regRdata;
  endtask : rd
endmodule : asol_host

// ---- asol_core_bench.sv ----
// Self-checking bench for the alarm/offset core.
// Assumes asol_host as the register master and one 25 MHz clock.
`timescale 1ns/1ns
module asol_core_bench;
  logic             clk = 1'h0;
  logic             rst = 1'h1;
  logic             sampleValid = 1'h0;
  logic             selfTestFail = 1'h0;
  logic             spiFail = 1'h0;
  logic             flashFail = 1'h0;
  logic [7:0][13:0] unfData = '0;
  logic [7:0][13:0] filtData = 112'h0CE4;
  logic             regWr, l1o, l1e, l2o, l2e;
  logic [5:0]       regAddr;
  logic [15:0]      regWdata, regRdata;
  logic [4:0][13:0] corrOut;
  int               miscompares = 0;
  int               totalChecks = 0;

  always #20 clk = ~clk;

  asol_host i_asol_host (.clk(clk), .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata));
  asol_core i_asol_core (.clk(clk), .rst(rst), .regWr(regWr), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sampleValid(sampleValid), .unfData(unfData),
    .filtData(filtData), .selfTestFail(selfTestFail), .spiFail(spiFail),
    .flashFail(flashFail), .corrOut(corrOut), .lineOneOut(l1o), .lineOneOe(l1e),
    .lineTwoOut(l2o), .lineTwoOe(l2e));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_asol_host.rd(a, v);
    chk(v, exp);
  endtask : rchk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_asol_host.wr(a, d);
  endtask : wr

  task automatic smp(input int s, input logic [13:0] u, input logic [13:0] f);
    @(posedge clk);
    unfData[s] <= u;
    filtData[s] <= f;
    sampleValid <= 1'h1;
    @(posedge clk);
    sampleValid <= 1'h0;
  endtask : smp

  task automatic doReset;
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
  endtask : doReset

  task automatic finalReport;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finalReport

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic tRegs;
    for (int i = 0; i < 13; i++) rchk(6'(2 * i), (i == 7 || i == 8) ? 16'h1 : 16'h0);
    chk({14'h0, l1e, l2e}, 16'h0000);
    // The command word is skipped: its restore bit would wipe the offsets again.
    for (int i = 0; i < 12; i++) if (i != 10) wr(6'(2 * i), 16'hFFFF);
    for (int i = 0; i < 10; i++) rchk(6'(2 * i), i < 5 ? 16'h3FFF : i < 7 ? 16'hBFFF :
      i < 9 ? 16'h00FF : 16'hFF7F);
    rchk(6'h16, 16'h0000);
    doReset;
  endtask : tRegs

  task automatic tOffset;
    wr(6'h00, 16'h0005);
    wr(6'h08, 16'h3FFE);
    filtData[1] <= 14'h000A;
    filtData[7] <= 14'h0007;
    repeat (2) @(posedge clk);
    chk({2'h0, corrOut[0]}, 16'h000F);
    chk({2'h0, corrOut[4]}, 16'h0005);
    wr(6'h14, 16'h0001);
    rchk(6'h00, 16'h3FF6);
    wr(6'h14, 16'h0002);
    rchk(6'h00, 16'h0000);
  endtask : tOffset

  task automatic tStatic;
    wr(6'h0A, 16'h8064);
    for (int k = 1; k < 9; k++) begin
      wr(6'h12, 16'(k << 8) | 16'h000E);
      smp(k - 1, 14'h0, k == 1 ? 14'h0D48 : 14'h00C8);
      smp(k - 1, 14'h0, k == 1 ? 14'h0CE4 : 14'h0000);
      rchk(6'h16, 16'h0100);
      chk({14'h0, l1e, l1o}, 16'h0003);
      wr(6'h14, 16'h0010);
      rchk(6'h16, 16'h0000);
      chk({14'h0, l1e, l1o}, 16'h0002);
    end
    wr(6'h12, 16'h0600);
    smp(5, 14'h00C8, 14'h0000);
    rchk(6'h16, 16'h0000);
    wr(6'h12, 16'h0200);
    smp(1, 14'h00C8, 14'h0000);
    rchk(6'h16, 16'h0100);
    wr(6'h14, 16'h0010);
    wr(6'h0A, 16'h0064);
    // Channel one still reads unfiltered data here, so both words carry the value.
    smp(1, 14'h00C8, 14'h00C8);
    rchk(6'h16, 16'h0000);
    smp(1, 14'h0032, 14'h0032);
    rchk(6'h16, 16'h0100);
    wr(6'h14, 16'h0010);
    wr(6'h0C, 16'h8064);
    wr(6'h12, 16'h2015);
    smp(1, 14'h0, 14'h00C8);
    rchk(6'h16, 16'h0200);
    chk({14'h0, l2e, l2o}, 16'h0002);
    wr(6'h14, 16'h0010);
    wr(6'h12, 16'hF904);
    smp(1, 14'h0, 14'h00C8);
    rchk(6'h16, 16'h0000);
  endtask : tStatic

  task automatic tRate(input logic [15:0] n, input logic [4:0][13:0] v);
    doReset;
    wr(6'h12, 16'h0228);
    wr(6'h0A, 16'h800A);
    wr(6'h0E, n);
    for (int j = 4; j >= 0; j--) begin
      smp(1, 14'h0, v[j]);
      if (j == 2) rchk(6'h16, 16'h0000);
    end
    rchk(6'h16, 16'h0100);
  endtask : tRate

  task automatic tErrors;
    // The sticky alarm left by the rate scenario is cleared first.
    wr(6'h14, 16'h0010);
    rchk(6'h16, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {selfTestFail, spiFail, flashFail} <= 3'h4 >> k;
      @(posedge clk);
      {selfTestFail, spiFail, flashFail} <= 3'h0;
      rchk(6'h16, k == 0 ? 16'h0020 : k == 1 ? 16'h0008 : 16'h0004);
      wr(6'h14, 16'h0010);
      rchk(6'h16, 16'h0000);
    end
    filtData[0] <= 14'h0E74;
    rchk(6'h16, 16'h0002);
    filtData[0] <= 14'h0B54;
    rchk(6'h16, 16'h0001);
    filtData[0] <= 14'h0BB8;
    rchk(6'h16, 16'h0000);
  endtask : tErrors

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    tRegs;
    tOffset;
    tStatic;
    tRate(16'h0002, {14'd0, 14'd15, 14'd15, 14'd45, 14'd75});
    tRate(16'h0000, {14'd0, 14'd0, 14'd5, 14'd20, 14'd20});
    tErrors;
    finalReport;
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finalReport;
  end
endmodule : asol_core_bench
